// File: verilog/adc_cfg_pkg.sv
// Shared constants and types for the ADC serial configuration port
package adc_cfg_pkg;

	// Frame layout: address first, then data, both MSB first
	localparam int ADDR_BITS = 8;
	localparam int DATA_BITS = 16;
	localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;
	localparam int NUM_REGS = 2 ** ADDR_BITS;
	localparam int CNT_W = 5;
	localparam int FRAME_ADDR_MSB = FRAME_BITS - 1;
	localparam int FRAME_ADDR_LSB = DATA_BITS;
	localparam int FRAME_DATA_MSB = DATA_BITS - 1;

	// Bit counter landmarks
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [CNT_W-1:0] CNT_ADDR_DONE = 5'h08;
	localparam logic [CNT_W-1:0] CNT_FRAME_DONE = 5'h18;

	// Register addresses and field positions
	localparam logic [ADDR_BITS-1:0] ADDR_SOFT_RESET = 8'h00;
	localparam logic [ADDR_BITS-1:0] ADDR_READBACK = 8'h01;
	localparam int SOFT_RESET_BIT = 7;
	localparam int READBACK_EN_BIT = 0;

	// Reset values
	localparam logic [DATA_BITS-1:0] REG_DEFAULT = 16'h0000;
	localparam logic [DATA_BITS-1:0] READ_HIDDEN = 16'h0000;
	localparam logic [FRAME_BITS-1:0] FRAME_CLEAR = 24'h000000;

	// Pin synchroniser order: {hw_reset, cs_b, sclk, serial_data_in}; chip select idles high
	localparam int SYNC_W = 4;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 4'h4;

	// Timing: system clock and shortest hardware reset pulse the port must catch
	localparam int CLK_PERIOD_NS = 40;
	localparam int RESET_PULSE_NS = 50;
	localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_FRAME = 2'b10
	} port_state_t;

endpackage

// File: verilog/pin_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	// First stage feeds only the second; clock enable freezes both
	always_comb begin
		meta_next = clk_en_i ? async_i : meta_reg;
		sync_next = clk_en_i ? meta_reg : sync_reg;
	end

	// Registers only
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_reg <= RESET_VAL;
			sync_reg <= RESET_VAL;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_o = sync_reg;

endmodule

// File: verilog/adc_serial_config_port.sv
// Serial configuration port: frame capture, register store and readback
`timescale 1ns/1ps
module adc_serial_config_port (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic cs_b_i,
	input wire logic sclk_i,
	input wire logic serial_data_in_i,
	input wire logic hw_reset_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_o,
	output logic readback_en_o,
	output logic reg_wr_o,
	output logic [adc_cfg_pkg::ADDR_BITS-1:0] reg_addr_o,
	output logic [adc_cfg_pkg::DATA_BITS-1:0] reg_data_o,
	output logic regs_init_o
);

	logic [adc_cfg_pkg::SYNC_W-1:0] pins_s;
	logic hw_rst_s;
	logic cs_b_s;
	logic sclk_s;
	logic sdin_s;

	adc_cfg_pkg::port_state_t state_reg;
	adc_cfg_pkg::port_state_t state_next;
	logic [adc_cfg_pkg::CNT_W-1:0] cnt_reg;
	logic [adc_cfg_pkg::CNT_W-1:0] cnt_next;
	logic [adc_cfg_pkg::FRAME_BITS-1:0] shift_reg;
	logic [adc_cfg_pkg::FRAME_BITS-1:0] shift_next;
	logic [adc_cfg_pkg::DATA_BITS-1:0] out_reg;
	logic [adc_cfg_pkg::DATA_BITS-1:0] out_next;
	logic sclk_d_reg;
	logic sclk_d_next;
	logic rb_en_reg;
	logic rb_en_next;
	logic oe_reg;
	logic oe_next;
	logic wr_reg;
	logic wr_next;
	logic [adc_cfg_pkg::ADDR_BITS-1:0] waddr_reg;
	logic [adc_cfg_pkg::ADDR_BITS-1:0] waddr_next;
	logic [adc_cfg_pkg::DATA_BITS-1:0] wdata_reg;
	logic [adc_cfg_pkg::DATA_BITS-1:0] wdata_next;
	logic init_reg;
	logic init_next;

	logic [adc_cfg_pkg::DATA_BITS-1:0] mem [adc_cfg_pkg::NUM_REGS];
	logic mem_we;
	logic mem_clr;

	logic sclk_fall;
	logic sclk_rise;
	logic commit;
	logic [adc_cfg_pkg::ADDR_BITS-1:0] frame_addr;
	logic [adc_cfg_pkg::DATA_BITS-1:0] frame_data;
	logic [adc_cfg_pkg::ADDR_BITS-1:0] rd_addr;
	logic [adc_cfg_pkg::DATA_BITS-1:0] rd_word;

	// All pins are asynchronous to clk_i, so each passes two flops first
	pin_sync #(
		.WIDTH(adc_cfg_pkg::SYNC_W),
		.RESET_VAL(adc_cfg_pkg::SYNC_RESET)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.clk_en_i(clk_en_i),
		.async_i({hw_reset_i, cs_b_i, sclk_i, serial_data_in_i}),
		.sync_o(pins_s)
	);

	assign {hw_rst_s, cs_b_s, sclk_s, sdin_s} = pins_s;

	// Serial clock edges found by oversampling; limits the link to well under clk_i / 2
	assign sclk_fall = sclk_d_reg & ~sclk_s;
	assign sclk_rise = ~sclk_d_reg & sclk_s;

	// Frame fields at commit time, address on top
	assign frame_addr = shift_reg[adc_cfg_pkg::FRAME_ADDR_MSB:adc_cfg_pkg::FRAME_ADDR_LSB];
	assign frame_data = shift_reg[adc_cfg_pkg::FRAME_DATA_MSB:0];

	// Address of a readback, complete once the eighth bit lands
	assign rd_addr = {shift_reg[adc_cfg_pkg::ADDR_BITS-2:0], sdin_s};
	// The readback control register never shows its own contents
	assign rd_word = (rd_addr == adc_cfg_pkg::ADDR_READBACK) ?
		adc_cfg_pkg::READ_HIDDEN : mem[rd_addr];

	// Frame engine, register commit and readback shifter
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		out_next = out_reg;
		sclk_d_next = sclk_s;
		rb_en_next = rb_en_reg;
		wr_next = 1'b0;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		init_next = 1'b0;
		commit = 1'b0;
		mem_we = 1'b0;
		mem_clr = 1'b0;
		if (hw_rst_s) begin
			// Pin reset wins over everything and aborts any frame
			state_next = adc_cfg_pkg::ST_IDLE;
			cnt_next = adc_cfg_pkg::CNT_ZERO;
			shift_next = adc_cfg_pkg::FRAME_CLEAR;
			out_next = adc_cfg_pkg::REG_DEFAULT;
			rb_en_next = 1'b0;
			init_next = 1'b1;
			mem_clr = 1'b1;
		end else begin
			unique case (state_reg)
				adc_cfg_pkg::ST_IDLE: begin
					cnt_next = adc_cfg_pkg::CNT_ZERO;
					out_next = adc_cfg_pkg::REG_DEFAULT;
					if (!cs_b_s) begin
						state_next = adc_cfg_pkg::ST_FRAME;
					end
				end
				adc_cfg_pkg::ST_FRAME: begin
					if (cs_b_s) begin
						// Partial frame is simply forgotten
						state_next = adc_cfg_pkg::ST_IDLE;
						cnt_next = adc_cfg_pkg::CNT_ZERO;
						out_next = adc_cfg_pkg::REG_DEFAULT;
					end else if (sclk_fall && cnt_reg != adc_cfg_pkg::CNT_FRAME_DONE) begin
						// MSB arrives first and walks up the shifter
						shift_next = {shift_reg[adc_cfg_pkg::FRAME_BITS-2:0], sdin_s};
						cnt_next = cnt_reg + adc_cfg_pkg::CNT_ONE;
						if (cnt_next == adc_cfg_pkg::CNT_ADDR_DONE) begin
							// D15 is ready before the ninth rising edge
							out_next = rb_en_reg ? rd_word : adc_cfg_pkg::REG_DEFAULT;
						end else if (cnt_reg > adc_cfg_pkg::CNT_ADDR_DONE) begin // D15 holds for bit 9
							out_next = {out_reg[adc_cfg_pkg::DATA_BITS-2:0], 1'b0};
						end
					end else if (sclk_rise && cnt_reg == adc_cfg_pkg::CNT_FRAME_DONE) begin
						// Count restarts so the next 24 bits form a new frame
						commit = 1'b1;
						cnt_next = adc_cfg_pkg::CNT_ZERO;
					end
				end
			endcase
			if (commit) begin
				if (rb_en_reg && frame_addr != adc_cfg_pkg::ADDR_READBACK) begin
					// Readback mode locks out every other register
					wr_next = 1'b0;
				end else if (frame_addr == adc_cfg_pkg::ADDR_SOFT_RESET) begin
					wr_next = 1'b1;
					waddr_next = frame_addr;
					wdata_next = frame_data;
					if (frame_data[adc_cfg_pkg::SOFT_RESET_BIT]) begin
						// Reset bit is never stored, so it reads back cleared
						rb_en_next = 1'b0;
						init_next = 1'b1;
						mem_clr = 1'b1;
					end
				end else begin
					wr_next = 1'b1;
					waddr_next = frame_addr;
					wdata_next = frame_data;
					mem_we = 1'b1;
					if (frame_addr == adc_cfg_pkg::ADDR_READBACK) begin
						rb_en_next = frame_data[adc_cfg_pkg::READBACK_EN_BIT];
					end
				end
			end
		end
		// Output floats whenever readback is off
		oe_next = rb_en_next;
	end

	// Frame and control registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= adc_cfg_pkg::ST_IDLE;
			cnt_reg <= adc_cfg_pkg::CNT_ZERO;
			shift_reg <= adc_cfg_pkg::FRAME_CLEAR;
			out_reg <= adc_cfg_pkg::REG_DEFAULT;
			sclk_d_reg <= 1'b0;
			rb_en_reg <= 1'b0;
			oe_reg <= 1'b0;
			wr_reg <= 1'b0;
			waddr_reg <= adc_cfg_pkg::ADDR_SOFT_RESET;
			wdata_reg <= adc_cfg_pkg::REG_DEFAULT;
			init_reg <= 1'b0;
		end else if (clk_en_i) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			out_reg <= out_next;
			sclk_d_reg <= sclk_d_next;
			rb_en_reg <= rb_en_next;
			oe_reg <= oe_next;
			wr_reg <= wr_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			init_reg <= init_next;
		end
	end

	// Register store; a clear returns every word to its default at once
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++) begin
				mem[i] <= adc_cfg_pkg::REG_DEFAULT;
			end
		end else if (clk_en_i) begin
			if (mem_clr) begin
				for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++) begin
					mem[i] <= adc_cfg_pkg::REG_DEFAULT;
				end
			end else if (mem_we) begin
				mem[frame_addr] <= frame_data;
			end
		end
	end

	// Outputs straight from flops
	assign serial_data_out_o = out_reg[adc_cfg_pkg::DATA_BITS-1];
	assign serial_data_out_oe_o = oe_reg;
	assign readback_en_o = rb_en_reg;
	assign reg_wr_o = wr_reg;
	assign reg_addr_o = waddr_reg;
	assign reg_data_o = wdata_reg;
	assign regs_init_o = init_reg;

	// With chip select high the bit count is held at zero
	a_idle_no_count: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(clk_en_i && cs_b_s && state_reg == adc_cfg_pkg::ST_FRAME) |=>
		(cnt_reg == adc_cfg_pkg::CNT_ZERO && state_reg == adc_cfg_pkg::ST_IDLE))
		else $error("count not cleared when chip select rose");

	// A falling edge inside a frame lands the data bit in the shifter
	a_sample_falling: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(clk_en_i && !hw_rst_s && !cs_b_s && state_reg == adc_cfg_pkg::ST_FRAME && sclk_fall
		&& cnt_reg < adc_cfg_pkg::CNT_FRAME_DONE) |=>
		(shift_reg[0] == $past(sdin_s) && cnt_reg == $past(cnt_reg) + adc_cfg_pkg::CNT_ONE))
		else $error("falling edge did not shift in a bit");

	// Rising edge after 24 bits writes the frame next cycle and restarts the count
	a_commit_frame: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(clk_en_i && !hw_rst_s && !cs_b_s && state_reg == adc_cfg_pkg::ST_FRAME && sclk_rise
		&& cnt_reg == adc_cfg_pkg::CNT_FRAME_DONE && !rb_en_reg
		&& shift_reg[adc_cfg_pkg::FRAME_ADDR_MSB:adc_cfg_pkg::FRAME_ADDR_LSB]
		!= adc_cfg_pkg::ADDR_SOFT_RESET) |=>
		(reg_wr_o && reg_data_o == $past(shift_reg[adc_cfg_pkg::FRAME_DATA_MSB:0])
		&& cnt_reg == adc_cfg_pkg::CNT_ZERO))
		else $error("full frame was not committed");

	// Count never runs past one frame, so surplus bits start the next frame
	a_count_bound: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cnt_reg <= adc_cfg_pkg::CNT_FRAME_DONE)
		else $error("bit count exceeded one frame");

	// No write without a completed frame the cycle before
	a_write_cause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(reg_wr_o) |-> $past(cnt_reg) == adc_cfg_pkg::CNT_FRAME_DONE)
		else $error("write without a full frame");

	// Soft reset clears readback and signals initialisation
	a_soft_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(clk_en_i && commit && !rb_en_reg && frame_addr == adc_cfg_pkg::ADDR_SOFT_RESET
		&& frame_data[adc_cfg_pkg::SOFT_RESET_BIT]) |=>
		(regs_init_o && !readback_en_o && !serial_data_out_oe_o))
		else $error("soft reset did not take effect");

	// Pin reset forces defaults on the following cycle
	a_pin_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(clk_en_i && hw_rst_s) |=> (regs_init_o && !readback_en_o && !reg_wr_o))
		else $error("pin reset did not take effect");

	// Output driven exactly while readback is enabled
	a_oe_readback: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		serial_data_out_oe_o == readback_en_o)
		else $error("output enable disagrees with readback mode");

	// Writes to other registers are dropped while reading back
	a_block_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(clk_en_i && commit && rb_en_reg && frame_addr != adc_cfg_pkg::ADDR_READBACK)
		|=> !reg_wr_o)
		else $error("write accepted in readback mode");

	// Readback control register shifts out as zeros
	a_hide_ctrl: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(clk_en_i && !hw_rst_s && !cs_b_s && state_reg == adc_cfg_pkg::ST_FRAME && sclk_fall
		&& cnt_reg == adc_cfg_pkg::CNT_ADDR_DONE - adc_cfg_pkg::CNT_ONE
		&& rd_addr == adc_cfg_pkg::ADDR_READBACK) |=> out_reg == adc_cfg_pkg::READ_HIDDEN)
		else $error("readback control register was exposed");

	// Readback word loaded at the eighth falling edge
	a_load_word: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(clk_en_i && !hw_rst_s && !cs_b_s && state_reg == adc_cfg_pkg::ST_FRAME && sclk_fall
		&& rb_en_reg && cnt_reg == adc_cfg_pkg::CNT_ADDR_DONE - adc_cfg_pkg::CNT_ONE) |=>
		out_reg == $past(rd_word))
		else $error("readback word not loaded");

endmodule

// File: tb/host_cfg_model.sv
// Host controller model that drives the configuration link
`timescale 1ns/1ps
module host_cfg_model (
	output logic cs_b_o,
	output logic sclk_o,
	output logic serial_data_in_o,
	input wire logic serial_data_out_i
);
	// Serial clock idles high between frames
	initial begin
		cs_b_o = 1'b1;
		sclk_o = 1'b1;
		serial_data_in_o = 1'b0;
	end

	// Shift nbits of w MSB first, repeating w per frame; readback taken from bits 9 to 24
	task automatic xfer(input logic [23:0] w, input int nbits, output logic [15:0] rd);
		rd = 16'h0000;
		// Step 10 ns before chip select falls; the step adds up over calls, so pin changes can land on a system clock edge
		#10;
		cs_b_o = 1'b0;
		#160;
		for (int i = 0; i < nbits; i++) begin
			serial_data_in_o = w[23 - (i % 24)];
			#120;
			sclk_o = 1'b0;
			// Long low phase lets each readback bit settle before the rise
			#200;
			sclk_o = 1'b1;
			if ((i % 24) >= 8) begin
				rd = {rd[14:0], serial_data_out_i};
			end
		end
		#160;
		cs_b_o = 1'b1;
		serial_data_in_o = ~serial_data_in_o; // Released line shows no stale bit
		#320;
	endtask

	// Clock pulses with chip select high, which must be ignored
	task automatic stray(input int n);
		for (int i = 0; i < n; i++) begin
			serial_data_in_o = ~serial_data_in_o;
			#160 sclk_o = 1'b0;
			#160 sclk_o = 1'b1;
		end
	endtask
endmodule

// File: tb/adc_serial_config_port_bench.sv
// Self-checking bench for the serial configuration port
`timescale 1ns/1ps
module adc_serial_config_port_bench;
	logic clk_i;
	logic rst_b_i;
	logic clk_en_i;
	logic hw_reset_i;
	wire logic cs_b;
	wire logic sclk;
	wire logic serial_data_in;
	wire logic sdo_wire;
	logic sdo;
	logic sdo_oe;
	logic rb_en;
	logic wr;
	logic init;
	logic [7:0] waddr;
	logic [15:0] wdata;
	logic [15:0] rd;
	int n_mismatch = 0;
	int checks = 0;
	int n_wr = 0;
	int n_init = 0;

	// Pin level seen by the host: floats while the port does not drive it
	assign sdo_wire = sdo_oe ? sdo : 1'bz;

	adc_serial_config_port dut (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.clk_en_i(clk_en_i),
		.cs_b_i(cs_b),
		.sclk_i(sclk),
		.serial_data_in_i(serial_data_in),
		.hw_reset_i(hw_reset_i),
		.serial_data_out_o(sdo),
		.serial_data_out_oe_o(sdo_oe),
		.readback_en_o(rb_en),
		.reg_wr_o(wr),
		.reg_addr_o(waddr),
		.reg_data_o(wdata),
		.regs_init_o(init)
	);

	host_cfg_model host (
		.cs_b_o(cs_b),
		.sclk_o(sclk),
		.serial_data_in_o(serial_data_in),
		.serial_data_out_i(sdo_wire)
	);

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// Count every cycle that each strobe is high so none is missed between checks
	always @(posedge clk_i) begin
		if (wr === 1'b1) n_wr++;
		if (init === 1'b1) n_init++;
	end

	task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic frame(input logic [7:0] a, input logic [15:0] d, input int nbits);
		host.xfer({a, d}, nbits, rd);
	endtask

	task automatic pin_reset();
		@(posedge clk_i);
		hw_reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		hw_reset_i <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask

	task automatic complete_run();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Bound on the whole run in case a frame never finishes
	initial begin
		#2000000;
		n_mismatch++;
		$display("ERROR t=%0t got=%0h exp=%0h", $time, 0, 1);
		complete_run();
	end

	initial begin
		rst_b_i = 1'b0;
		clk_en_i = 1'b1;
		hw_reset_i = 1'b0;
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		// Power-on delay before the pin reset pulse
		repeat (25000) @(posedge clk_i);
		pin_reset();
		cmp(n_init, 2);
		cmp({sdo_oe, rb_en}, 0);
		$display("test reset done");

		frame(8'h5A, 16'hC3A5, 24);
		cmp(n_wr, 1);
		cmp({waddr, wdata}, 24'h5AC3A5);
		host.stray(30);
		cmp(n_wr, 1);
		frame(8'h3C, 16'h1234, 10);
		cmp(n_wr, 1);
		frame(8'h3C, 16'h1234, 53);
		cmp(n_wr, 3);
		cmp({waddr, wdata}, 24'h3C1234);
		$display("test write done");

		frame(8'h01, 16'h0001, 24);
		cmp({sdo_oe, rb_en}, 3);
		frame(8'h5A, 16'h0000, 24);
		frame(8'h5A, 16'h0000, 24);
		cmp(rd, 16'hC3A5);
		frame(8'h3C, 16'h0000, 24);
		cmp(rd, 16'h1234);
		frame(8'h01, 16'h0000, 24);
		cmp(rd, 16'h0000);
		cmp(n_wr, 5);
		cmp({sdo_oe, rb_en}, 0);
		$display("test readback done");

		frame(8'h00, 16'h0080, 24);
		cmp(n_init, 3);
		frame(8'h01, 16'h0001, 24);
		frame(8'h3C, 16'h0000, 24);
		cmp(rd, 16'h0000);
		pin_reset();
		cmp(n_init, 5);
		cmp({sdo_oe, rb_en}, 0);
		// Clock enable low freezes the synchronisers, so a short pin pulse goes unseen
		clk_en_i <= 1'b0;
		pin_reset();
		cmp(n_init, 5);
		clk_en_i <= 1'b1;
		$display("test soft reset done");
		complete_run();
	end
endmodule
